// ---- hw/cache_cfg_regs.sv ----
// Purpose: Cache presence and SDRAM control registers
// Assumes: Read data is valid in the cycle after the read strobe
// Notes:   Presence bit follows the reset strap and ignores writes
`timescale 1ns/1ps
`default_nettype none
module cache_cfg_regs
	import l2_cache_pkg::*;
(
	input  wire logic       mclk,         // host clock
	input  wire logic       rstn,         // async reset, active low
	input  wire logic [7:0] regAddr,      // register offset
	input  wire logic [7:0] regWdata,     // write data
	input  wire logic       regWr,        // write strobe
	input  wire logic       regRd,        // read strobe
	output logic      [7:0] regRdata,     // read data, one cycle later
	input  wire logic       cachePresent, // strapped DRAM cache flag
	output logic            fifthCsEnable // SDRAM control bit 1
);
	typedef struct packed {
		logic [7:0] presence;
		logic [7:0] sdram;
		logic [7:0] rdata;
	} regs_s;

	regs_s s_q;
	regs_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.presence[CACHE_PRESENT_BIT] = cachePresent;
		if (regWr && regAddr == REG_CACHE_PRESENCE)
		begin
			s_d.presence = regWdata;
			s_d.presence[CACHE_PRESENT_BIT] = cachePresent;
		end
		if (regWr && regAddr == REG_SYNC_DRAM)
		begin
			s_d.sdram = regWdata;
		end
		if (regRd)
		begin
			case (regAddr)
				REG_CACHE_PRESENCE: s_d.rdata = s_q.presence;
				REG_SYNC_DRAM:      s_d.rdata = s_q.sdram;
				default:            s_d.rdata = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q.presence <= RST_CACHE_PRESENCE;
			s_q.sdram    <= RST_SYNC_DRAM;
			s_q.rdata    <= UNMAPPED_READ;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign regRdata      = s_q.rdata;
	assign fifthCsEnable = s_q.sdram[FIFTH_CS_EN_BIT];
endmodule : cache_cfg_regs
`default_nettype wire

// ---- hw/l2_cache_sram_tag_interface.sv ----
// Purpose: Control of burst SRAM data RAMs, tag RAM and the dual-use pin
// Assumes: Tag RAM and data RAMs run on mclk; dual pin is asynchronous
// Notes:   One request at a time, taken while reqReady is high
//
// What this block does
// [R1] Address strobe with chip select active wakes the cache and runs access.
// [R2] Address strobe with chip select inactive puts the cache to sleep.
// [R3] With chip select inactive the cache ignores the processor strobe.
// [R4] Processor strobe with chip select active wakes cache and runs access.
// [R5] Output enable low whenever data RAMs must drive the processor bus.
// [R6] Global write enable writes all byte lanes of powered RAMs.
// [R7] Partial writes: global high, byte enable low, byte lanes pick bytes.
// [R8] Tag bus is input on processor access, driven on fill and invalidate.
// [R9] Tag write enable stores new state and presented tag address.
// [R10] With a DRAM cache the dual pin is a refresh request/acknowledge.
// [R11] Otherwise the dual pin may serve as fifth SDRAM row select.
// [R12] The dual pin is sampled at hard reset to find a DRAM cache.
// [R13] Fifth select only when control bit 1 set and presence bit clear.
// [R14] DRAM cache present or control bit clear selects the refresh role.
// [R15] Cache address strobe loads the burst SRAM address register.
// [R16] Cache advance steps the burst SRAM to the next quadword.
// [R17] Never both write enables in one cycle; one write path per write.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module l2_cache_sram_tag_interface
	import l2_cache_pkg::*;
(
	input  wire logic       mclk,             // host clock, 50 MHz
	input  wire logic       rstn,             // async reset, active low
	input  wire logic [7:0] regAddr,          // register offset
	input  wire logic [7:0] regWdata,         // register write data
	input  wire logic       regWr,            // register write strobe
	input  wire logic       regRd,            // register read strobe
	output logic      [7:0] regRdata,         // register read data
	input  wire logic       reqValid,         // cache request present
	input  wire op_e        reqOp,            // kind of request
	input  wire logic [7:0] reqByteEnablesN,  // byte lanes, low = write
	input  wire logic [7:0] reqTag,           // tag and state to store
	output logic            reqReady,         // high in idle; request taken if valid
	output logic            reqDone,          // request finished, pulse
	output logic      [7:0] tagSeen,          // tag read during access
	output logic            tagSeenValid,     // tagSeen updated, pulse
	output logic            cacheChipSelectN, // cache chip select
	output logic            cacheAddrStrobeN, // cache address strobe
	output logic            cacheAdvanceN,    // cache advance
	output logic            cacheOutputEnableN, // cache output enable
	output logic            globalWriteEnableN, // all-lane write
	output logic            byteWriteEnableN, // per-lane write
	output logic      [7:0] cacheByteLanesN,  // byte lanes to the RAMs
	input  wire logic [7:0] tagBusIn,         // tag bus level
	output logic      [7:0] tagBusOut,        // tag bus drive value
	output logic            tagBusOeN,        // tag bus enable, low drives
	output logic            tagWriteEnableN,  // tag write enable
	input  wire logic       refreshReq,       // refresh wanted, level
	output logic            refreshDone,      // refresh acknowledged, pulse
	output logic            refreshAsk,       // cache asks for refresh
	input  wire logic       fifthRowSelectReqN, // fifth row select source
	input  wire logic       dualPinIn,        // dual pin level
	output logic            dualPinOut,       // dual pin drive value
	output logic            dualPinOeN,       // dual pin enable, low drives
	output logic            fifthSelMode,     // pin acts as row select
	output logic            dramCachePresent  // strapped at reset
);
	// ==========================================================
	// State
	typedef struct packed {
		cache_st_e   st;
		logic [1:0]  beat;
		logic        partial;
		logic        ccsN;
		logic        cadsN;
		logic        cadvN;
		logic        coeN;
		logic        gweN;
		logic        bweN;
		logic [7:0]  laneN;
		logic [7:0]  tagOut;
		logic        tagOeN;
		logic        tweN;
		logic [7:0]  tagSeen;
		logic        tagSeenVld;
		logic        done;
		refresh_st_e rf;
		logic        rfDone;
		logic        rfAsk;
		logic        pinOut;
		logic        pinOeN;
		logic [2:0]  strapCnt;
		logic        strapDone;
		logic        dramCache;
	} top_s;

	top_s s_q;
	top_s s_d;

	logic pinLevel;
	logic fifthCsEnable;
	logic fifthMode;

	// ==========================================================
	// Pin synchroniser and registers
	pin_sync3 u_sync (
		.mclk  (mclk),
		.rstn  (rstn),
		.pinIn (dualPinIn),
		.level (pinLevel)
	);

	cache_cfg_regs u_regs (
		.mclk          (mclk),
		.rstn          (rstn),
		.regAddr       (regAddr),
		.regWdata      (regWdata),
		.regWr         (regWr),
		.regRd         (regRd),
		.regRdata      (regRdata),
		.cachePresent  (s_q.dramCache),
		.fifthCsEnable (fifthCsEnable)
	);

	// [R13] Fifth select gate
	assign fifthMode = fifthCsEnable && !s_q.dramCache;

	// ==========================================================
	// Next state
	always_comb
	begin
		s_d            = s_q;
		s_d.cadsN      = 1'b1;
		s_d.cadvN      = 1'b1;
		s_d.gweN       = 1'b1;
		s_d.bweN       = 1'b1;
		s_d.tweN       = 1'b1;
		s_d.tagSeenVld = 1'b0;
		s_d.done       = 1'b0;
		s_d.rfDone     = 1'b0;

		case (s_q.st)
			ST_IDLE:
			begin
				s_d.coeN   = 1'b1;
				s_d.tagOeN = 1'b1;
				s_d.beat   = 2'h0;
				if (reqValid)
				begin
					s_d.laneN   = reqByteEnablesN;
					s_d.tagOut  = reqTag;
					s_d.partial = 1'b0;
					case (reqOp)
						// [R1] Strobe with select active
						OP_READ:
						begin
							s_d.ccsN  = 1'b0;
							s_d.cadsN = 1'b0;
							s_d.st    = ST_READ;
						end
						OP_WRITE:
						begin
							s_d.ccsN  = 1'b0;
							s_d.cadsN = 1'b0;
							s_d.st    = ST_WRITE;
						end
						// [R7] Partial write path chosen
						OP_WRITE_BYTES:
						begin
							s_d.ccsN    = 1'b0;
							s_d.cadsN   = 1'b0;
							s_d.partial = 1'b1;
							s_d.st      = ST_WRITE;
						end
						// [R8] Tag driven for line fill
						OP_FILL:
						begin
							s_d.ccsN   = 1'b0;
							s_d.cadsN  = 1'b0;
							s_d.tagOeN = 1'b0;
							s_d.st     = ST_FILL;
						end
						// [R8] Tag driven for invalidate
						OP_INVAL:
						begin
							s_d.tagOeN = 1'b0;
							s_d.st     = ST_INVAL;
						end
						// [R2] Strobe with select inactive
						OP_SLEEP:
						begin
							s_d.ccsN  = 1'b1;
							s_d.cadsN = 1'b0;
							s_d.done  = 1'b1;
						end
						default:
						begin
							s_d.done = 1'b1;
						end
					endcase
				end
			end
			ST_READ:
			begin
				// [R5] RAMs drive the bus for the burst
				s_d.coeN = 1'b0;
				// [R8] Tag bus sampled as input
				if (s_q.beat == 2'h0)
				begin
					s_d.tagSeen    = tagBusIn;
					s_d.tagSeenVld = 1'b1;
				end
				if (s_q.beat == LAST_BEAT)
				begin
					s_d.coeN = 1'b1;
					s_d.done = 1'b1;
					s_d.st   = ST_IDLE;
				end
				else
				begin
					// [R16] Step to next quadword
					s_d.cadvN = 1'b0;
					s_d.beat  = s_q.beat + 2'h1;
				end
			end
			ST_WRITE:
			begin
				// [R17] Exactly one write path
				if (s_q.partial)
				begin
					s_d.bweN = 1'b0;
				end
				else
				begin
					// [R6] All byte lanes written
					s_d.gweN = 1'b0;
				end
				s_d.done = 1'b1;
				s_d.st   = ST_IDLE;
			end
			ST_FILL:
			begin
				// [R6] All byte lanes written each beat
				s_d.gweN = 1'b0;
				if (s_q.beat == LAST_BEAT)
				begin
					// [R9] Store tag with the last beat
					s_d.tweN = 1'b0;
					s_d.done = 1'b1;
					s_d.st   = ST_IDLE;
				end
				else
				begin
					s_d.cadvN = 1'b0;
					s_d.beat  = s_q.beat + 2'h1;
				end
			end
			ST_INVAL:
			begin
				// [R9] New state written with tag
				s_d.tweN = 1'b0;
				s_d.done = 1'b1;
				s_d.st   = ST_IDLE;
			end
			default:
			begin
				s_d.st = ST_IDLE;
			end
		endcase

		// ======================================================
		// Strap capture and dual pin
		if (!s_q.strapDone)
		begin
			// [R12] Pin floats until the strap is taken
			s_d.pinOeN = 1'b1;
			if (s_q.strapCnt == STRAP_SETTLE)
			begin
				s_d.dramCache = pinLevel;
				s_d.strapDone = 1'b1;
			end
			else
			begin
				s_d.strapCnt = s_q.strapCnt + 3'h1;
			end
		end
		else if (fifthMode)
		begin
			// [R11] Pin is the fifth row select
			s_d.rf     = RF_IDLE;
			s_d.rfAsk  = 1'b0;
			s_d.pinOut = fifthRowSelectReqN;
			s_d.pinOeN = 1'b0;
		end
		else
		begin
			// [R14] Refresh handshake role
			s_d.rfAsk = 1'b0;
			case (s_q.rf)
				// [R10] Request out, acknowledge in
				RF_IDLE:
				begin
					s_d.pinOeN = 1'b1;
					s_d.rfAsk  = pinLevel;
					if (refreshReq && !pinLevel)
					begin
						s_d.pinOut = 1'b1;
						s_d.pinOeN = 1'b0;
						s_d.rf     = RF_DRIVE;
					end
				end
				RF_DRIVE:
				begin
					s_d.pinOut = 1'b0;
					s_d.pinOeN = 1'b1;
					s_d.rf     = RF_WAIT;
				end
				RF_WAIT:
				begin
					if (pinLevel)
					begin
						s_d.rfDone = 1'b1;
						s_d.rf     = RF_IDLE;
					end
				end
				default:
				begin
					s_d.rf = RF_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q.st         <= ST_IDLE;
			s_q.beat       <= 2'h0;
			s_q.partial    <= 1'b0;
			s_q.ccsN       <= 1'b1;
			s_q.cadsN      <= 1'b1;
			s_q.cadvN      <= 1'b1;
			s_q.coeN       <= 1'b1;
			s_q.gweN       <= 1'b1;
			s_q.bweN       <= 1'b1;
			s_q.laneN      <= 8'hff;
			s_q.tagOut     <= 8'h00;
			s_q.tagOeN     <= 1'b1;
			s_q.tweN       <= 1'b1;
			s_q.tagSeen    <= 8'h00;
			s_q.tagSeenVld <= 1'b0;
			s_q.done       <= 1'b0;
			s_q.rf         <= RF_IDLE;
			s_q.rfDone     <= 1'b0;
			s_q.rfAsk      <= 1'b0;
			s_q.pinOut     <= 1'b0;
			s_q.pinOeN     <= 1'b1;
			s_q.strapCnt   <= 3'h0;
			s_q.strapDone  <= 1'b0;
			s_q.dramCache  <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	// [R3] [R4] Processor strobe only counts while select is low
	assign cacheChipSelectN   = s_q.ccsN;
	// [R15] Address load strobe
	assign cacheAddrStrobeN   = s_q.cadsN;
	assign cacheAdvanceN      = s_q.cadvN;
	assign cacheOutputEnableN = s_q.coeN;
	assign globalWriteEnableN = s_q.gweN;
	assign byteWriteEnableN   = s_q.bweN;
	assign cacheByteLanesN    = s_q.laneN;
	assign tagBusOut          = s_q.tagOut;
	assign tagBusOeN          = s_q.tagOeN;
	assign tagWriteEnableN    = s_q.tweN;
	assign tagSeen            = s_q.tagSeen;
	assign tagSeenValid       = s_q.tagSeenVld;
	assign reqReady           = (s_q.st == ST_IDLE);
	assign reqDone            = s_q.done;
	assign refreshDone        = s_q.rfDone;
	assign refreshAsk         = s_q.rfAsk;
	assign dualPinOut         = s_q.pinOut;
	assign dualPinOeN         = s_q.pinOeN;
	assign fifthSelMode       = s_q.strapDone && fifthMode;
	assign dramCachePresent   = s_q.dramCache;
endmodule : l2_cache_sram_tag_interface
`default_nettype wire

// ---- hw/pin_sync3.sv ----
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin idles low through its pull-down
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
	import l2_cache_pkg::*;
(
	input  wire logic mclk,   // host clock
	input  wire logic rstn,   // async reset, active low
	input  wire logic pinIn,  // raw pin level
	output logic      level   // filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	always_comb
	begin
		s_d     = s_q;
		s_d.s1  = pinIn;
		s_d.s2  = s_q.s1;
		s_d.s3  = s_q.s2;
		if (s_q.s2 == s_q.s3)
		begin
			s_d.lvl = s_q.s3;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign level = s_q.lvl;
endmodule : pin_sync3
`default_nettype wire

// ---- pkg/l2_cache_pkg.sv ----
// Purpose: Shared constants and types for the second-level cache control block
// Assumes: One host clock, plain register port with 8-bit offsets
// Notes:   Reset values of both registers are zero
`default_nettype none
package l2_cache_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CACHE_PRESENCE = 8'h53;
	localparam logic [7:0] REG_SYNC_DRAM      = 8'h54;
	localparam logic [7:0] RST_CACHE_PRESENCE = 8'h00;
	localparam logic [7:0] RST_SYNC_DRAM      = 8'h00;
	localparam int         CACHE_PRESENT_BIT  = 5;
	localparam int         FIFTH_CS_EN_BIT    = 1;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// ==========================================================
	// Timing
	localparam int         BURST_BEATS        = 4;
	localparam logic [1:0] LAST_BEAT          = 2'h3;
	// Sync pipe is three deep plus one agreement cycle, with margin
	localparam logic [2:0] STRAP_SETTLE       = 3'h5;

	// ==========================================================
	// Request kinds and states
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_WRITE_BYTES,
		OP_FILL,
		OP_INVAL,
		OP_SLEEP
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_FILL,
		ST_INVAL
	} cache_st_e;

	typedef enum logic [1:0] {
		RF_IDLE,
		RF_DRIVE,
		RF_WAIT
	} refresh_st_e;
endpackage : l2_cache_pkg
`default_nettype wire

// ---- verification/cache_ram_model.sv ----
// Purpose: Tag RAM, data RAM power state and dual pin far side
// Assumes: Pins resolve here; pull-downs when released
// Notes:   Tag RAM holds one line and is not reset
`timescale 1ns/1ps
`default_nettype none
module cache_ram_model
	import l2_cache_pkg::*;
(
	input  wire logic       mclk,             // clock
	input  wire logic       rstn,             // reset
	input  wire logic       strapHigh,        // DRAM cache
	input  wire logic [3:0] ackDelay,         // ack wait
	input  wire logic       cacheChipSelectN, // select
	input  wire logic       cacheAddrStrobeN, // strobe
	input  wire logic [7:0] tagBusOut,        // drive
	input  wire logic       tagBusOeN,        // enable
	input  wire logic       tagWriteEnableN,  // write
	input  wire logic       dualPinOut,       // drive
	input  wire logic       dualPinOeN,       // enable
	output logic      [7:0] tagBusIn,         // wire
	output logic            dualPinIn         // wire
);
	logic [7:0] tagMem = 8'h00;
	logic       awake;
	logic       oeLast;
	int         cnt;
	int         since;
	// ==========================================================
	// wire levels
	// A strobe under select wakes the RAMs in the cycle it is seen
	assign tagBusIn = !tagBusOeN ? tagBusOut
		: ((awake || !cacheAddrStrobeN) && !cacheChipSelectN) ? tagMem
		: 8'h00;
	assign dualPinIn = !dualPinOeN ? dualPinOut
		: ((cnt > 0 && cnt <= 6) || (since < 12 && strapHigh));
	always @(posedge mclk)
		if (!tagWriteEnableN)
			tagMem <= tagBusIn;
	always @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			awake <= 1'b0;
			oeLast <= 1'b1;
			cnt <= 0;
			since <= 0;
		end
		else
		begin
			since <= since + 1;
			oeLast <= dualPinOeN;
			// power follows every strobe: on under select, off without
			if (!cacheAddrStrobeN)
				awake <= !cacheChipSelectN;
			if (!dualPinOeN && oeLast && dualPinOut)
				cnt <= 32'(ackDelay) + 6;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
endmodule : cache_ram_model
`default_nettype wire

// ---- verification/l2_cache_asserts.sv ----
// Purpose: Port checks for the cache control block
// Assumes: One clock domain
// Notes:   Bound to the top module after endmodule
`timescale 1ns/1ps
`default_nettype none
module l2_cache_asserts
	import l2_cache_pkg::*;
(
	input wire logic       mclk,               // clock
	input wire logic       rstn,               // reset
	input wire logic       reqValid,           // req
	input wire op_e        reqOp,              // kind
	input wire logic [7:0] reqByteEnablesN,    // lanes
	input wire logic [7:0] reqTag,             // tag
	input wire logic       reqReady,           // idle
	input wire logic       reqDone,            // end
	input wire logic       tagSeenValid,       // tag pulse
	input wire logic       cacheChipSelectN,   // pin
	input wire logic       cacheAddrStrobeN,   // pin
	input wire logic       cacheAdvanceN,      // pin
	input wire logic       cacheOutputEnableN, // pin
	input wire logic       globalWriteEnableN, // pin
	input wire logic       byteWriteEnableN,   // pin
	input wire logic [7:0] cacheByteLanesN,    // pins
	input wire logic [7:0] tagBusOut,          // drive
	input wire logic       tagBusOeN,          // enable
	input wire logic       tagWriteEnableN,    // pin
	input wire logic       fifthRowSelectReqN, // source
	input wire logic       dualPinOut,         // drive
	input wire logic       dualPinOeN,         // enable
	input wire logic       fifthSelMode        // mode
);
	// ==========================================================
	// Checks
	logic take;
	assign take = reqValid && reqReady;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	rd_burst_a: assert property (
		take && reqOp == OP_READ |=> !cacheChipSelectN && !cacheAddrStrobeN
		##1 !cacheOutputEnableN && !cacheAdvanceN && tagSeenValid
		##1 (!cacheOutputEnableN && !cacheAdvanceN) [*2]
		##1 cacheOutputEnableN && reqDone && tagBusOeN)
		else $error("read burst wrong");
	wr_global_a: assert property (
		take && reqOp == OP_WRITE
		|=> ##1 !globalWriteEnableN && byteWriteEnableN && reqDone)
		else $error("global write wrong");
	wr_bytes_a: assert property (
		take && reqOp == OP_WRITE_BYTES |=> ##1 globalWriteEnableN
		&& !byteWriteEnableN && cacheByteLanesN == $past(reqByteEnablesN, 2))
		else $error("byte write wrong");
	one_path_a: assert property (
		globalWriteEnableN || byteWriteEnableN)
		else $error("both write enables low");
	fill_line_a: assert property (
		take && reqOp == OP_FILL |=> !tagBusOeN
		##1 (!tagBusOeN && !globalWriteEnableN) [*3]
		##1 !tagBusOeN && !tagWriteEnableN && reqDone ##1 tagBusOeN)
		else $error("fill wrong");
	inval_tag_a: assert property (
		take && reqOp == OP_INVAL |=> !tagBusOeN ##1 !tagWriteEnableN
		&& tagBusOut == $past(reqTag, 2) && reqDone ##1 tagBusOeN)
		else $error("invalidate wrong");
	sleep_cmd_a: assert property (
		take && reqOp == OP_SLEEP
		|=> cacheChipSelectN && !cacheAddrStrobeN && reqDone)
		else $error("sleep wrong");
	refresh_pulse_a: assert property (
		$fell(dualPinOeN) && !fifthSelMode
		|-> dualPinOut ##1 dualPinOeN || fifthSelMode)
		else $error("refresh drive wrong");
	row_select_a: assert property (
		fifthSelMode && $past(fifthSelMode)
		|-> !dualPinOeN && dualPinOut == $past(fifthRowSelectReqN))
		else $error("row select wrong");
endmodule : l2_cache_asserts
bind l2_cache_sram_tag_interface l2_cache_asserts chk (
	.mclk, .rstn, .reqValid, .reqOp, .reqByteEnablesN, .reqTag,
	.reqReady, .reqDone, .tagSeenValid, .cacheChipSelectN, .cacheAddrStrobeN,
	.cacheAdvanceN, .cacheOutputEnableN, .globalWriteEnableN,
	.byteWriteEnableN, .cacheByteLanesN, .tagBusOut, .tagBusOeN,
	.tagWriteEnableN, .fifthRowSelectReqN, .dualPinOut, .dualPinOeN,
	.fifthSelMode
);
`default_nettype wire

// ---- verification/tb_l2_cache_sram_tag_interface.sv ----
// Purpose: Self-checking bench for the cache control block
// Assumes: Partner model on tag bus and dual pin
// Notes:   Latencies follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module tb_l2_cache_sram_tag_interface
	import l2_cache_pkg::*;
;
	logic       mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic       reqValid = 1'b0, refreshReq = 1'b0, strapHigh = 1'b0;
	logic       fifthRowSelectReqN = 1'b1;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, reqTag = 8'h00;
	logic [7:0] reqByteEnablesN = 8'hff, tagModel = 8'h00, d, v;
	logic [7:0] regRdata, tagSeen, cacheByteLanesN, tagBusIn, tagBusOut;
	logic       reqReady, reqDone, tagSeenValid, cacheChipSelectN;
	logic       cacheAddrStrobeN, cacheAdvanceN, cacheOutputEnableN;
	logic       globalWriteEnableN, byteWriteEnableN, tagBusOeN;
	logic       tagWriteEnableN, refreshDone, refreshAsk, dualPinIn;
	logic       dualPinOut, dualPinOeN, fifthSelMode, dramCachePresent;
	logic [3:0] ackDelay = 4'h0;
	op_e        reqOp = OP_READ;
	op_e        ops [8] = '{OP_FILL, OP_READ, OP_WRITE, OP_WRITE_BYTES,
		OP_SLEEP, OP_READ, OP_INVAL, OP_READ};
	int         lats [8] = '{5, 5, 2, 2, 1, 5, 2, 5};
	int         failCount = 0, comparisons = 0, seed = 50, n;
	always #10 mclk = ~mclk;
	l2_cache_sram_tag_interface dut (
		.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.reqValid, .reqOp, .reqByteEnablesN, .reqTag, .reqReady, .reqDone,
		.tagSeen, .tagSeenValid, .cacheChipSelectN, .cacheAddrStrobeN,
		.cacheAdvanceN, .cacheOutputEnableN, .globalWriteEnableN,
		.byteWriteEnableN, .cacheByteLanesN, .tagBusIn, .tagBusOut,
		.tagBusOeN, .tagWriteEnableN, .refreshReq, .refreshDone,
		.refreshAsk, .fifthRowSelectReqN, .dualPinIn, .dualPinOut,
		.dualPinOeN, .fifthSelMode, .dramCachePresent);
	cache_ram_model ram (.mclk, .rstn, .strapHigh, .ackDelay,
		.cacheChipSelectN, .cacheAddrStrobeN, .tagBusOut, .tagBusOeN,
		.tagWriteEnableN, .dualPinOut, .dualPinOeN, .tagBusIn, .dualPinIn);
	// ==========================================================
	// Tasks
	task automatic closeOut;
		$display("Counts: %0d compared, %0d failed", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : closeOut
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failCount++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	// Bounded wait; a wait that runs out ends the run
	task automatic waitHigh(input bit pickRefresh, output int cnt);
		logic sig;
		// Count the edge at which the pulse is sampled, take edge is zero
		cnt = 1;
		#1;
		sig = pickRefresh ? refreshDone : reqDone;
		while (sig !== 1'b1 && cnt < 60)
		begin
			@(posedge mclk);
			#1;
			cnt++;
			sig = pickRefresh ? refreshDone : reqDone;
		end
		if (sig !== 1'b1)
		begin
			failCount++;
			$display("Error at %0t: wait ran out", $time);
			closeOut();
		end
	endtask : waitHigh
	task automatic regAccess(input bit wr, input logic [7:0] a,
		input logic [7:0] wd);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= wd;
		regWr <= wr;
		regRd <= !wr;
		@(posedge mclk);
		regWr <= 1'b0;
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask : regAccess
	task automatic request(input op_e op, input int lat);
		@(posedge mclk);
		reqValid <= 1'b1;
		reqOp <= op;
		reqTag <= 8'($random(seed));
		reqByteEnablesN <= 8'($random(seed));
		@(posedge mclk);
		reqValid <= 1'b0;
		waitHigh(1'b0, n);
		check(8'(n), 8'(lat));
		if (op == OP_FILL || op == OP_INVAL)
			tagModel = reqTag;
		if (op == OP_READ)
			check(tagSeen, tagModel);
	endtask : request
	// ==========================================================
	// Sequence
	initial
	begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		regAccess(1'b0, REG_CACHE_PRESENCE, 8'h00);
		check(d, RST_CACHE_PRESENCE);
		regAccess(1'b0, 8'h60, 8'h00);
		check(d, UNMAPPED_READ);
		regAccess(1'b1, REG_CACHE_PRESENCE, 8'h20);
		regAccess(1'b0, REG_CACHE_PRESENCE, 8'h00);
		check({7'h00, d[CACHE_PRESENT_BIT]}, 8'h00);
		v = 8'($random(seed)) & 8'hfd;
		regAccess(1'b1, REG_SYNC_DRAM, v);
		regAccess(1'b1, 8'h60, 8'hff);
		regAccess(1'b0, REG_SYNC_DRAM, 8'h00);
		check(d, v);
		$display("Test registers done");
		repeat (3)
			for (int i = 0; i < 8; i++)
				request(ops[i], lats[i]);
		$display("Test requests done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge mclk);
			ackDelay <= 4'(k * 9);
			refreshReq <= 1'b1;
			waitHigh(1'b1, n);
			check(8'(n < 16 + k * 9), 8'h01);
			@(posedge mclk);
			refreshReq <= 1'b0;
			#1;
			check({7'h00, refreshAsk}, 8'h01);
			repeat (20) @(posedge mclk);
			#1;
			check({7'h00, refreshAsk}, 8'h00);
		end
		$display("Test refresh done");
		regAccess(1'b1, REG_SYNC_DRAM, 8'h02);
		repeat (30)
			@(posedge mclk) fifthRowSelectReqN <= 1'($random(seed));
		check({7'h00, fifthSelMode}, 8'h01);
		$display("Test row select done");
		rstn <= 1'b0;
		strapHigh <= 1'b1;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		repeat (20) @(posedge mclk);
		regAccess(1'b1, REG_SYNC_DRAM, 8'h02);
		regAccess(1'b0, REG_CACHE_PRESENCE, 8'h00);
		check({7'h00, d[CACHE_PRESENT_BIT]}, 8'h01);
		check({6'h00, fifthSelMode, dramCachePresent}, 8'h01);
		$display("Test strapped cache done");
		closeOut();
	end
endmodule : tb_l2_cache_sram_tag_interface
`default_nettype wire
